// File: rtl/dba_node.sv
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "dba_defs.svh"
module dba_node (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Shared bus lines, logical asserted level
   input wire logic [9:0] req_in,
   output logic [9:0] req_out,
   output logic [9:0] req_oe,
   input wire logic ca_in,
   output logic ca_out,
   output logic ca_oe,
   input wire logic stall_in,
   input wire logic err_in,
   output logic err_out,
   output logic err_oe,
   input wire logic [38:0] d_in,
   output logic [38:0] d_out,
   output logic d_oe,
   input wire logic [2:0] slot_id_strap,
   // User side
   input wire logic module_request,
   input wire logic [37:0] cmd_word,
   output logic req_taken,
   output logic granted,
   output logic cmd_seen_v,
   output logic [37:0] cmd_seen
);
   import dba_pkg::*;

   dba_state_type s_reg;
   dba_state_type s_next;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Bank of a command word; register and private ones map to 0
   function automatic logic [5:0] cmd_bank(input logic [37:0] w);
      logic [2:0] c;
      c = w[`DBA_CMD_LSB +: 3];
      if (c == `DBA_CMD_CSR_RD || c == `DBA_CMD_CSR_WR ||
          c == `DBA_CMD_PRIV) begin
         cmd_bank = 6'h00;
      end else begin
         cmd_bank = w[`DBA_BANK_LSB +: 6];
      end
   endfunction : cmd_bank

   // Highest asserted line number
   function automatic logic [3:0] top_line(input logic [9:0] v);
      top_line = 4'hF;
      for (int i = 0; i < 10; i++) begin
         if (v[i]) begin
            top_line = 4'(i);
         end
      end
   endfunction : top_line

   // Processor lines 9:6,4:1 packed into priority order
   function automatic logic [7:0] cpu_lines(input logic [9:0] v);
      cpu_lines = {v[9:6], v[4:1]};
   endfunction : cpu_lines

   // ----------------------------------------------------------------
   // Combinational decisions
   // ----------------------------------------------------------------
   logic [5:0] req_bank;
   logic bank_ok;
   logic [3:0] want_line;
   logic [3:0] node_id;
   logic asrt;
   logic win;
   logic cmd_det;
   logic cmd_ok;
   logic cpu_command_cycle;
   logic case1;
   logic case2;
   logic case3;
   logic [3:0] cpu_priority_reg_idx;

   // Target bank, bank busy check and line choice
   always_comb begin
      req_bank = cmd_bank(cmd_word);
      bank_ok = !((req_bank == s_reg.prior_bank &&
                   s_reg.prior_cnt != 4'h0) ||
                  (req_bank == s_reg.last_bank &&
                   s_reg.last_cnt != 4'h0));
      cpu_priority_reg_idx = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (s_reg.cpu_priority_reg[i]) begin
            cpu_priority_reg_idx = 4'(i);
         end
      end
      if (s_reg.ctrl_io) begin
         // After a top-priority access to a bank, next goes low
         want_line = (s_reg.io_hi_used && req_bank == s_reg.io_hi_bank) ?
                     `DBA_IO_LO_LINE : `DBA_IO_HI_LINE;
         node_id = `DBA_IO_NODE_ID;
      end else begin
         // One-hot priority picks one unique processor line
         want_line = (cpu_priority_reg_idx < 4'h4) ? cpu_priority_reg_idx + 4'h1 :
                     cpu_priority_reg_idx + 4'h2;
         node_id = {1'b0, s_reg.strap2};
      end
   end

   // Request permission, grant and command recognition
   always_comb begin
      asrt = module_request && s_reg.ctrl_en &&
             (s_reg.ca_h[2] || !s_reg.req_any_h3) &&
             (s_reg.req_h2 == 10'h000) && !s_reg.ca_h[1] &&
             !s_reg.asrt_h[0] &&
             !s_reg.cycle_mask_a[2] && bank_ok;
      win = s_reg.asrt_h[1] &&
            top_line(s_reg.req_h2) == s_reg.hold_line &&
            !s_reg.req_any_h3 && !s_reg.ca_h[1] &&
            !s_reg.ca_h[2] && !s_reg.ca_h[3];
      cmd_det = ca_in && (s_reg.req_h2 != 10'h000) &&
                (s_reg.ca_h == 4'h0);
      cmd_ok = cmd_det && (^d_in);
      cpu_command_cycle = cmd_det && !s_reg.req_h2[5] &&
              (cpu_lines(s_reg.req_h2) != 8'h00);
      case1 = err_in || (s_reg.err_h != 2'h0) ||
              (s_reg.reload != 2'h0);
      case2 = cpu_command_cycle && !s_reg.ctrl_io &&
              ({s_reg.req_h2[5], cpu_lines(s_reg.req_h2)} >=
               {s_reg.cpu_priority_reg, 1'b0}) && !case1;
      case3 = cpu_command_cycle && !s_reg.ctrl_io &&
              ((cpu_lines(s_reg.req_h2) & s_reg.cpu_priority_reg) != 8'h00) &&
              !case2 && !case1;
   end

   // ----------------------------------------------------------------
   // Bus line drivers
   // ----------------------------------------------------------------
   // Request line, node number in command cycle, command and error
   always_comb begin
      req_oe = 10'h000;
      if (asrt) begin
         req_oe[want_line] = 1'b1;
      end
      if (win) begin
         req_oe[3:0] = req_oe[3:0] | node_id;
      end
      req_out = req_oe;
      ca_oe = win;
      ca_out = win;
      d_oe = win;
      d_out = {~(^s_reg.hold_cmd), s_reg.hold_cmd};
      err_oe = s_reg.err_pend;
      err_out = s_reg.err_pend;
   end

   assign req_taken = asrt;
   assign granted = s_reg.granted;
   assign cmd_seen = s_reg.cmd_seen;
   assign cmd_seen_v = s_reg.cmd_seen_v;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      // Bus history
      s_next.req_h1 = req_in;
      s_next.req_h2 = s_reg.req_h1;
      s_next.req_any_h3 = |s_reg.req_h2;
      s_next.ca_h = {s_reg.ca_h[2:0], ca_in};
      s_next.stall_h = {s_reg.stall_h[0], stall_in};
      s_next.err_h = {s_reg.err_h[0], err_in};
      s_next.asrt_h = {s_reg.asrt_h[0], asrt};
      s_next.strap1 = slot_id_strap;
      s_next.strap2 = s_reg.strap1;
      if (s_reg.reload != 2'h0) begin
         s_next.reload = s_reg.reload - 2'h1;
      end
      if (asrt) begin
         s_next.hold_cmd = cmd_word;
         s_next.hold_line = want_line;
      end
      s_next.granted = win;
      // Allocation mask, low bit is the nearest cycle
      s_next.cycle_mask_a = s_reg.stall_h[1] ? s_reg.cycle_mask_a :
                     {1'b0, s_reg.cycle_mask_a[16:1]};
      if (s_reg.ca_h[0]) begin
         s_next.cycle_mask_a = s_next.cycle_mask_a | (s_reg.stall_h[1] ?
                        17'(`DBA_CMD_PATTERN << 1) :
                        `DBA_CMD_PATTERN);
      end
      if (s_reg.err_h[0] || s_reg.reload != 2'h0) begin
         s_next.cycle_mask_a = `DBA_CYCLE_MASK_A_ONES;
      end
      // Bank history and countdowns
      if (s_reg.last_cnt != 4'h0 && !stall_in) begin
         s_next.last_cnt = s_reg.last_cnt - 4'h1;
      end
      if (s_reg.prior_cnt != 4'h0 && !stall_in) begin
         s_next.prior_cnt = s_reg.prior_cnt - 4'h1;
      end
      if (cmd_ok) begin
         s_next.prior_bank = s_reg.last_bank;
         s_next.last_bank = cmd_bank(d_in[37:0]);
         s_next.prior_cnt = (s_reg.last_cnt != 4'h0 && !stall_in) ?
                            s_reg.last_cnt - 4'h1 :
                            s_reg.last_cnt;
         s_next.last_cnt = stall_in ? `DBA_BANK_LOAD :
                           `DBA_BANK_LOAD - 4'h1;
      end
      // Seen commands and parity errors
      s_next.cmd_seen_v = cmd_ok;
      if (cmd_ok) begin
         s_next.cmd_seen = d_in[37:0];
      end
      s_next.err_pend = cmd_det && !cmd_ok;
      if (cmd_det && !cmd_ok) begin
         s_next.perr_cnt = s_reg.perr_cnt + 16'h0001;
      end
      // I/O node top-priority bookkeeping once a request resolves
      if (s_reg.ctrl_io && s_reg.asrt_h[1]) begin
         if (s_reg.hold_line == `DBA_IO_HI_LINE && win) begin
            s_next.io_hi_used = 1'b1;
            s_next.io_hi_bank = cmd_bank(s_reg.hold_cmd);
         end else if (s_reg.hold_line == `DBA_IO_LO_LINE &&
                      cmd_bank(s_reg.hold_cmd) == s_reg.io_hi_bank) begin
            s_next.io_hi_used = 1'b0;
         end
      end
      // Rotating processor priority
      if (case1) begin
         s_next.cpu_priority_reg = `DBA_CPU_PRIORITY_REG_LOW << s_reg.strap2;
      end else if (case2) begin
         s_next.cpu_priority_reg = s_reg.cpu_priority_reg << 1;
      end else if (case3) begin
         s_next.cpu_priority_reg = `DBA_CPU_PRIORITY_REG_LOW;
      end else begin
         s_next.cpu_priority_reg = s_reg.cpu_priority_reg;
      end
      // AHB-Lite address phase capture and register access
      s_next.ahb_wr = hsel && htrans[1] && hready && hwrite;
      s_next.ahb_addr = haddr[7:0];
      if (s_reg.ahb_wr && s_reg.ahb_addr == `DBA_CTRL_OFS) begin
         s_next.ctrl_en = hwdata[`DBA_CTRL_EN_BIT];
         s_next.ctrl_io = hwdata[`DBA_CTRL_IO_BIT];
      end
      s_next.rdata = 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite) begin
         unique case (haddr[7:0])
            `DBA_CTRL_OFS: s_next.rdata = {30'h0, s_reg.ctrl_io,
                                           s_reg.ctrl_en};
            `DBA_STAT_OFS: s_next.rdata = {3'h0, s_reg.io_hi_used,
               s_reg.prior_cnt, s_reg.last_cnt, s_reg.prior_bank,
               s_reg.last_bank, s_reg.cpu_priority_reg};
            `DBA_CYCLE_MASK_A_OFS: s_next.rdata = {15'h0, s_reg.cycle_mask_a};
            `DBA_PERR_OFS: s_next.rdata = {16'h0, s_reg.perr_cnt};
            default: s_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register, synchronous reset
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_reg <= '0;
         s_reg.cycle_mask_a <= `DBA_CYCLE_MASK_A_ONES;
         s_reg.reload <= `DBA_RELOAD_CNT;
         s_reg.cpu_priority_reg <= `DBA_CPU_PRIORITY_REG_LOW;
         s_reg.ctrl_en <= `DBA_CTRL_EN_RST;
         s_reg.ctrl_io <= `DBA_CTRL_IO_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   property p_no_twice;
      asrt |=> !asrt;
   endproperty
   a_no_twice: assert property (p_no_twice)
      else $error("request raised in two cycles running");

   property p_cycle_mask_a_gate;
      asrt |-> !s_reg.cycle_mask_a[2] && bank_ok;
   endproperty
   a_cycle_mask_a_gate: assert property (p_cycle_mask_a_gate)
      else $error("request despite mask bit 2 or busy bank");

   property p_issue_delay;
      win |-> $past(asrt, 2) && $past(req_in, 2) != 10'h000;
   endproperty
   a_issue_delay: assert property (p_issue_delay)
      else $error("command without request two cycles before");

   property p_issue_quiet;
      win |-> !$past(ca_in, 2) && !$past(ca_in, 3) && !$past(ca_in, 4) &&
              $past(req_in, 3) == 10'h000;
   endproperty
   a_issue_quiet: assert property (p_issue_quiet)
      else $error("command right after strobe history");

   property p_parity_out;
      d_oe |-> ^d_out && ca_oe && req_oe[3:0] == (req_oe[3:0] | node_id);
   endproperty
   a_parity_out: assert property (p_parity_out)
      else $error("command word parity or node number wrong");

   property p_err_soon;
      (cmd_det && !cmd_ok) |-> ##[1:4] err_oe;
   endproperty
   a_err_soon: assert property (p_err_soon)
      else $error("parity error not flagged in four cycles");

   property p_cycle_mask_a_all;
      $rose(err_in) |-> ##2 s_reg.cycle_mask_a == `DBA_CYCLE_MASK_A_ONES;
   endproperty
   a_cycle_mask_a_all: assert property (p_cycle_mask_a_all)
      else $error("mask not filled after error");

   property p_self_win;
      case3 |=> s_reg.cpu_priority_reg == `DBA_CPU_PRIORITY_REG_LOW ##1 $stable(s_reg.cpu_priority_reg) ||
                case1 || case2 || case3;
   endproperty
   a_self_win: assert property (p_self_win)
      else $error("priority not lowest after own win");

   property p_onehot;
      $onehot(s_reg.cpu_priority_reg);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("priority not one-hot");

   property p_bank_load;
      cmd_ok && !stall_in |=> s_reg.last_cnt == 4'hC;
   endproperty
   a_bank_load: assert property (p_bank_load)
      else $error("newest bank counter not loaded");

endmodule : dba_node

// File: shared/dba_defs.svh
`ifndef DBA_DEFS_SVH
`define DBA_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses, low address byte)
// ----------------------------------------------------------------
`define DBA_CTRL_OFS 8'h00
`define DBA_STAT_OFS 8'h04
`define DBA_CYCLE_MASK_A_OFS 8'h08
`define DBA_PERR_OFS 8'h0C
// Control fields and reset values
`define DBA_CTRL_EN_BIT 0
`define DBA_CTRL_IO_BIT 1
`define DBA_CTRL_EN_RST 1'h1
`define DBA_CTRL_IO_RST 1'h0
// ----------------------------------------------------------------
// Arbitration constants
// ----------------------------------------------------------------
`define DBA_CYCLE_MASK_A_ONES 17'h1FFFF
`define DBA_CMD_PATTERN 17'h03DEF
`define DBA_BANK_LOAD 4'hD
`define DBA_CPU_PRIORITY_REG_LOW 8'h01
`define DBA_RELOAD_CNT 2'h3
`define DBA_IO_NODE_ID 4'h8
`define DBA_IO_HI_LINE 4'h5
`define DBA_IO_LO_LINE 4'h0
// Command word layout
`define DBA_CMD_LSB 35
`define DBA_BANK_LSB 1
`define DBA_CMD_CSR_RD 3'h4
`define DBA_CMD_CSR_WR 3'h5
`define DBA_CMD_PRIV 3'h7
`endif

// File: shared/dba_pkg.sv
package dba_pkg;
   // Whole node state, registered as one word
   typedef struct packed {
      logic [16:0] cycle_mask_a;
      logic [7:0] cpu_priority_reg;
      logic [9:0] req_h1;
      logic [9:0] req_h2;
      logic req_any_h3;
      logic [3:0] ca_h;
      logic [1:0] stall_h;
      logic [1:0] err_h;
      logic [1:0] asrt_h;
      logic err_pend;
      logic [1:0] reload;
      logic [2:0] strap1;
      logic [2:0] strap2;
      logic [5:0] last_bank;
      logic [5:0] prior_bank;
      logic [3:0] last_cnt;
      logic [3:0] prior_cnt;
      logic io_hi_used;
      logic [5:0] io_hi_bank;
      logic [37:0] hold_cmd;
      logic [3:0] hold_line;
      logic ctrl_en;
      logic ctrl_io;
      logic ahb_wr;
      logic [7:0] ahb_addr;
      logic [31:0] rdata;
      logic [15:0] perr_cnt;
      logic [37:0] cmd_seen;
      logic cmd_seen_v;
      logic granted;
   } dba_state_type;
endpackage : dba_pkg

// File: testbench/dba_far_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far node: one other bus node that requests and commands
// ----------------------------------------------------------------
module dba_far_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Bench control
   input wire logic go,
   input wire logic [3:0] line,
   input wire logic [37:0] word,
   input wire logic bad_par,
   // Bus lines driven, asserted high
   output logic [9:0] req_far,
   output logic ca_far,
   output logic [38:0] d_far
);
   // Far node number on monitor lines, arbitrary value
   localparam logic [3:0] FAR_ID = 4'h6;
   logic [1:0] step;
   logic par;
   // Odd parity, flipped on demand for the error case
   assign par = (~^word) ^ bad_par;
   // Request, one quiet cycle, command two cycles after request
   always_ff @(posedge clk_sys) begin
      req_far <= 10'h000;
      ca_far <= 1'b0;
      d_far <= 39'h0;  // Released lines go to the terminator level
      if (srst) begin
         step <= 2'h0;
      end else if (go) begin
         req_far <= 10'h001 << line;
         step <= 2'h1;
      end else if (step == 2'h1) begin
         step <= 2'h2;
      end else if (step == 2'h2) begin
         ca_far <= 1'b1;
         d_far <= {par, word};
         req_far <= {6'h00, FAR_ID};
         step <= 2'h0;
      end
   end
endmodule : dba_far_model

// File: testbench/tb.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bench for one arbitration node and one far node
// ----------------------------------------------------------------
module tb;
   import dba_pkg::*;
   logic clk_sys, srst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [9:0] req_in, req_out, req_oe, req_far;
   logic ca_in, ca_out, ca_oe, ca_far, err_out, err_oe, d_oe;
   logic [38:0] d_in, d_out, d_far;
   logic module_request, req_taken, granted, cmd_seen_v;
   logic [37:0] cmd_word, cmd_seen, word;
   logic go, bad_par, stall;
   logic [3:0] line;
   int failures, checks, cycles;
   // Open-drain bus: any driver asserts the line
   assign req_in = req_far | (req_out & req_oe);
   assign ca_in = ca_far | (ca_out & ca_oe);
   assign d_in = d_far | (d_oe ? d_out : 39'h0);
   assign hready = hreadyout;
   dba_node u_dut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .req_in(req_in),
      .req_out(req_out), .req_oe(req_oe), .ca_in(ca_in),
      .ca_out(ca_out), .ca_oe(ca_oe), .stall_in(stall),
      .err_in(err_out & err_oe), .err_out(err_out), .err_oe(err_oe),
      .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
      .slot_id_strap(3'h2), .module_request(module_request),
      .cmd_word(cmd_word), .req_taken(req_taken), .granted(granted),
      .cmd_seen_v(cmd_seen_v), .cmd_seen(cmd_seen));
   dba_far_model u_far (.clk_sys(clk_sys), .srst(srst), .go(go),
      .line(line), .word(word), .bad_par(bad_par),
      .req_far(req_far), .ca_far(ca_far), .d_far(d_far));
   // Clock, 40 ns period
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [37:0] exp,
         input logic [37:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Single AHB transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      d = hrdata;
   endtask : ahb
   task automatic t_regs();
      ahb(1'b0, 8'h00, 32'h0, rd);
      chk("ctrl reset", 38'h1, {6'h0, rd});
      chk("okay resp", 38'h0, {37'h0, hresp});
      ahb(1'b0, 8'h10, 32'h0, rd);
      chk("unmapped", 38'h0, {6'h0, rd});
      ahb(1'b1, 8'h00, 32'h3, rd);
      ahb(1'b0, 8'h00, 32'h0, rd);
      chk("ctrl write", 38'h3, {6'h0, rd});
      ahb(1'b1, 8'h00, 32'h1, rd);
      repeat (40) @(posedge clk_sys);
      ahb(1'b0, 8'h08, 32'h0, rd);
      chk("cycle_mask_a idle", 38'h0, {6'h0, rd});
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("cpu_priority_reg strap", 38'h04, {30'h0, rd[7:0]});
      $display("test regs done");
   endtask : t_regs
   task automatic t_own();
      int n;
      n = 0;
      @(posedge clk_sys);
      module_request <= 1'b1;
      cmd_word <= 38'hA;
      @(negedge clk_sys);
      while (req_taken !== 1'b1 && n < 60) begin
         n++;
         @(negedge clk_sys);
      end
      chk("req taken", 38'h1, {37'h0, req_taken});
      @(posedge clk_sys);
      module_request <= 1'b0;
      @(negedge clk_sys);
      chk("strobe early", 38'h0, {37'h0, ca_oe});
      @(negedge clk_sys);
      chk("strobe", 38'h1, {37'h0, ca_oe & d_oe});
      chk("cmd data", 38'hA, d_out[37:0]);
      chk("parity", {37'h0, ~^38'hA}, {37'h0, d_out[38]});
      chk("node id", 38'h2, {34'h0, req_oe[3:0] & req_out[3:0]});
      @(negedge clk_sys);
      chk("granted", 38'h1, {37'h0, granted & cmd_seen_v});
      chk("own seen", 38'hA, cmd_seen);
      repeat (30) @(posedge clk_sys);
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("cpu_priority_reg own win", 38'h01, {30'h0, rd[7:0]});
      chk("last bank", 38'h05, {32'h0, rd[13:8]});
      $display("test own done");
   endtask : t_own
   // Far node command; returns count of commands seen in window
   task automatic far_cmd(input logic [3:0] l, input logic [37:0] w,
         input logic b, output int seen, output int errs);
      seen = 0;
      errs = 0;
      @(posedge clk_sys);
      go <= 1'b1;
      line <= l;
      word <= w;
      bad_par <= b;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (8) begin
         @(negedge clk_sys);
         if (cmd_seen_v === 1'b1) seen++;
         if (err_oe === 1'b1) errs++;
      end
   endtask : far_cmd
   task automatic t_far();
      int s, e;
      // Stall held across the command freezes the bank countdowns
      @(posedge clk_sys);
      stall <= 1'b1;
      far_cmd(4'h9, 38'h12, 1'b0, s, e);
      chk("far seen", 38'h1, s[37:0]);
      chk("far word", 38'h12, cmd_seen);
      repeat (30) @(posedge clk_sys);
      ahb(1'b0, 8'h04, 32'h0, rd);
      stall <= 1'b0;
      chk("cpu_priority_reg shift", 38'h02, {30'h0, rd[7:0]});
      chk("stalled count", 38'hD, {34'h0, rd[23:20]});
      chk("prior count", 38'h0, {34'h0, rd[27:24]});
      chk("last bank", 38'h09, {32'h0, rd[13:8]});
      chk("prior bank", 38'h05, {32'h0, rd[19:14]});
      $display("test far done");
   endtask : t_far
   task automatic t_bad();
      int s, e;
      far_cmd(4'h5, 38'h14, 1'b1, s, e);
      chk("bad ignored", 38'h0, s[37:0]);
      chk("error pulse", 38'h1, e[37:0]);
      repeat (20) @(posedge clk_sys);
      ahb(1'b0, 8'h0C, 32'h0, rd);
      chk("perr count", 38'h1, {6'h0, rd});
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("cpu_priority_reg reload", 38'h04, {30'h0, rd[7:0]});
      chk("bank kept", 38'h09, {32'h0, rd[13:8]});
      $display("test bad parity done");
   endtask : t_bad
   // Raise the user request, wait at falling edges until taken
   task automatic raise_req(input logic [37:0] w);
      int n;
      n = 0;
      @(posedge clk_sys);
      module_request <= 1'b1;
      cmd_word <= w;
      @(negedge clk_sys);
      while (req_taken !== 1'b1 && n < 60) begin
         n++;
         @(negedge clk_sys);
      end
   endtask : raise_req
   // I/O node mode: top line once per bank, then the low line
   task automatic t_io();
      ahb(1'b1, 8'h00, 32'h3, rd);
      raise_req(38'h1A);
      chk("io taken", 38'h1, {37'h0, req_taken});
      chk("io high line", 38'h1, {37'h0, req_oe[5]});
      @(posedge clk_sys);
      module_request <= 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("io strobe", 38'h1, {37'h0, ca_oe});
      chk("io id", 38'h8, {34'h0, req_oe[3:0]});
      repeat (30) @(posedge clk_sys);
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("io high used", 38'h1, {37'h0, rd[28]});
      chk("io bank", 38'h0D, {32'h0, rd[13:8]});
      raise_req(38'h1A);
      chk("io low line", 38'h1, {37'h0, req_oe[0]});
      @(posedge clk_sys);
      module_request <= 1'b0;
      repeat (30) @(posedge clk_sys);
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk("io high freed", 38'h0, {37'h0, rd[28]});
      ahb(1'b1, 8'h00, 32'h1, rd);
      $display("test io done");
   endtask : t_io
   // Main sequence
   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      module_request = 1'b0;
      cmd_word = 38'h0;
      go = 1'b0;
      line = 4'h0;
      word = 38'h0;
      bad_par = 1'b0;
      stall = 1'b0;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      t_regs();
      t_own();
      t_far();
      t_bad();
      t_io();
      conclude();
   end
endmodule : tb
